// [verilog/dbmc_top.sv]
`timescale 1ns/1ps
`include "dbmc_map.svh"
module dbmc_top
  import dbmc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  input wire logic i_dma_req,
  input wire logic i_block_mode,
  input wire logic i_bus_style_select,
  input wire logic i_hold_grant,
  input wire logic i_grant_acknowledge,
  input wire logic i_ready_in,
  input wire logic i_port_ack,
  input wire logic i_bus_retry_input,
  input wire logic i_retry_pending_flag,
  input wire logic i_user_pin1_in,
  input wire logic i_user_pin0_in,
  output logic o_user_pin1_out,
  output logic o_user_pin0_out,
  output logic o_user_pin1_oe,
  output logic o_user_pin0_oe,
  output logic o_bus_request,
  output logic o_cycle_done,
  output logic o_cycle_active
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rst_m_q;
  logic rst_s_q;
  logic rst_b;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  assign rst_b = rst_s_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [6:0] raw;
  logic [6:0] syn;
  assign raw = {i_user_pin1_in, i_user_pin0_in, i_bus_retry_input,
                i_hold_grant, i_grant_acknowledge, i_ready_in, i_port_ack};
  dbmc_sync #(.W(7)) u_sync (
    .i_clk(i_clk),
    .i_rst_b(rst_b),
    .i_async(raw),
    .o_sync(syn)
  );
  logic pin1_s, pin0_s, retry_s, master_s, rdy_async;
  assign pin1_s = syn[6];
  assign pin0_s = syn[5];
  assign retry_s = syn[4];
  assign master_s = syn[3] | syn[2];
  // Async ready path through synchroniser
  assign rdy_async = i_bus_style_select ? syn[0] : syn[1];

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  logic [15:0] cfg_q, cfg_d;
  logic strap_done_q, strap_done_d;
  // Write decode; strap bits are read-only
  always_comb begin
    cfg_d = cfg_q;
    strap_done_d = 1'b1;
    if (!strap_done_q) begin
      cfg_d[`DBMC_BIT_STRAP1] = pin1_s;
      cfg_d[`DBMC_BIT_STRAP0] = pin0_s;
    end
    if (i_reg_wr && i_reg_addr == `DBMC_CFG_OFFSET) begin
      cfg_d = (i_reg_wdata & `DBMC_CFG_WMASK) | (cfg_d & ~`DBMC_CFG_WMASK);
    end
  end
  // Capture waits for synchronised pins, hence done flag held a while
  logic [1:0] strap_cnt_q, strap_cnt_d;
  always_comb begin
    strap_cnt_d = (strap_cnt_q == `DBMC_STRAP_WAIT) ? strap_cnt_q : strap_cnt_q + 2'h1;
  end
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= `DBMC_CFG_RESET;
      strap_cnt_q <= 2'h0;
      strap_done_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      strap_cnt_q <= strap_cnt_d;
      strap_done_q <= (strap_cnt_q == `DBMC_STRAP_WAIT) ? strap_done_d : 1'b0;
    end
  end
  assign o_reg_rdata = (i_reg_addr == `DBMC_CFG_OFFSET) ? cfg_q : 16'h0000;

  // ----------------------------------------
  // User pins while master
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      o_user_pin1_out <= 1'b0;
      o_user_pin0_out <= 1'b0;
    end else begin
      // Next value registered so the pins track a write with no lag
      o_user_pin1_out <= cfg_d[`DBMC_BIT_OUT1];
      o_user_pin0_out <= cfg_d[`DBMC_BIT_OUT0];
    end
  end
  // Drive only while master; inputs otherwise so the straps read
  assign o_user_pin1_oe = master_s;
  assign o_user_pin0_oe = master_s;

  // ----------------------------------------
  // DMA cycle engine
  // ----------------------------------------
  dbmc_state_type st_q, st_d;
  logic [1:0] wait_q, wait_d;
  logic retry_block_q, retry_block_d;
  logic done_d, done_q;
  logic rdy;
  // Ready: direct when synchronous and block DMA, else synchronised
  assign rdy = (cfg_q[`DBMC_BIT_SYNC_READY] && i_block_mode) ?
               (i_bus_style_select ? i_port_ack : i_ready_in)
               : rdy_async;
  always_comb begin
    st_d = st_q;
    wait_d = wait_q;
    done_d = 1'b0;
    retry_block_d = retry_block_q;
    // Retry hold: unlatched clears on release, latched also needs flag clear
    if (retry_block_q && !retry_s &&
        (!cfg_q[`DBMC_BIT_RETRY_LATCH] || !i_retry_pending_flag)) begin
      retry_block_d = 1'b0;
    end
    case (st_q)
      DBMC_IDLE: begin
        if (i_dma_req && master_s && !retry_block_q && !retry_s) begin
          st_d = DBMC_T1;
        end
      end
      DBMC_T1: begin
        st_d = DBMC_T2;
        wait_d = cfg_q[`DBMC_WAIT_HI:`DBMC_WAIT_LO];
      end
      DBMC_T2: begin
        if (wait_q != 2'h0) begin
          wait_d = wait_q - 2'h1;
        end else if (rdy) begin
          done_d = 1'b1;
          // Retry ends the operation and leaves the bus
          if (retry_s) begin
            retry_block_d = 1'b1;
            st_d = DBMC_HOLD;
          end else begin
            st_d = i_dma_req ? DBMC_T1 : DBMC_IDLE;
          end
        end
      end
      DBMC_HOLD: begin
        st_d = DBMC_IDLE;
      end
      default: begin
        st_d = DBMC_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= DBMC_IDLE;
      wait_q <= 2'h0;
      done_q <= 1'b0;
      retry_block_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wait_q <= wait_d;
      done_q <= done_d;
      retry_block_q <= retry_block_d;
    end
  end
  assign o_cycle_done = done_q;
  assign o_cycle_active = (st_q == DBMC_T1) || (st_q == DBMC_T2);
  assign o_bus_request = i_dma_req && !retry_block_q && (st_q != DBMC_HOLD);
endmodule

// [verilog/dbmc_map.svh]
// Functional notes
// - Unlatched retry: end cycle, resume when released.
// - Latched retry: also wait for flag clear.
// - User pins follow output levels while master.
// - Async ready: synchronised, taken in second state.
// - Sync ready: sampled directly, in second state only.
// - Ready mode applies only during block DMA.
// - Pin levels captured at reset release, held.
// - Wait count adds zero to three second-states.
`ifndef DBMC_MAP_SVH
`define DBMC_MAP_SVH
`define DBMC_CFG_OFFSET 6'h01
`define DBMC_BIT_RETRY_LATCH 13
`define DBMC_BIT_OUT1 12
`define DBMC_BIT_OUT0 11
`define DBMC_BIT_SYNC_READY 10
`define DBMC_BIT_STRAP1 9
`define DBMC_BIT_STRAP0 8
`define DBMC_WAIT_HI 7
`define DBMC_WAIT_LO 6
`define DBMC_CFG_RESET 16'h0000
`define DBMC_CFG_WMASK 16'hBCDF
`define DBMC_STRAP_WAIT 2'h3
`endif

// [verilog/dbmc_pkg.sv]
package dbmc_pkg;
  // DMA cycle states, one-hot
  typedef enum logic [3:0] {
    DBMC_IDLE = 4'h1,
    DBMC_T1 = 4'h2,
    DBMC_T2 = 4'h4,
    DBMC_HOLD = 4'h8
  } dbmc_state_type;
endpackage

// [verilog/dbmc_sync.sv]
`timescale 1ns/1ps
// Two-flop synchroniser for pin inputs
module dbmc_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // First flop feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end
  assign o_sync = sync_q;
endmodule

// [test/dbmc_bus_model.sv]
`timescale 1ns/1ps
// ---
// Arbiter, memory and retry source
// ---
module dbmc_bus_model (
  input wire logic i_clk,
  input wire logic i_bus_request,
  input wire logic i_cycle_active,
  input wire logic i_slow,
  input wire logic i_retry,
  output logic o_hold_grant,
  output logic o_ready,
  output logic o_retry
);
  // Answers change just after the rising edge; slow memory readies every other cycle
  always @(posedge i_clk) begin
    o_hold_grant <= i_bus_request;
    o_ready <= i_cycle_active & (~i_slow | ~o_ready);
    o_retry <= i_retry | (o_retry & i_cycle_active);
  end
endmodule

// [test/dbmc_check_monitor.sv]
`timescale 1ns/1ps
module dbmc_check (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [5:0] i_reg_addr,
  input wire logic i_hold_grant,
  input wire logic i_grant_acknowledge,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_user_pin1_out,
  input wire logic o_user_pin0_out,
  input wire logic o_user_pin1_oe,
  input wire logic o_user_pin0_oe,
  input wire logic o_cycle_done,
  input wire logic o_cycle_active
);
  // ---
  // Checks on the bus clock, off in reset
  // ---
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_start; $rose(o_cycle_active); endsequence
  // Grant lines low long enough to pass the pin synchroniser
  sequence s_lost; (!i_hold_grant && !i_grant_acknowledge) [*4]; endsequence
  logic cfg;
  assign cfg = i_reg_addr == 6'h01;
  pin1_follow_a: assert property (cfg && o_user_pin1_oe |-> o_user_pin1_out == o_reg_rdata[12])
    else $error("pin one level wrong");
  pin0_follow_a: assert property (cfg && o_user_pin0_oe |-> o_user_pin0_out == o_reg_rdata[11])
    else $error("pin zero level wrong");
  oe_pair_a: assert property (o_user_pin1_oe == o_user_pin0_oe)
    else $error("pin enables differ");
  oe_idle_a: assert property (s_lost |-> !o_user_pin1_oe)
    else $error("pin driven without grant");
  done_pulse_a: assert property (o_cycle_done |=> !o_cycle_done)
    else $error("done too long");
  done_after_a: assert property (o_cycle_done |-> $past(o_cycle_active))
    else $error("done without cycle");
  min_cycle_a: assert property (s_start |-> o_cycle_active [*2])
    else $error("cycle too short");
  max_wait_a: assert property ((cfg && o_reg_rdata[7:6] == 2'h3) ##0 s_start |-> o_cycle_active [*5])
    else $error("three waits missing");
endmodule
bind dbmc_top dbmc_check u_chk (.*);

// [test/test_dma_bus_master_config.sv]
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s exp %h got %h", n, e, g); end end
module test_dma_bus_master_config;
  // ---
  // Stimulus, model and design
  // ---
  logic i_clk = 0, i_rst_b = 0, wr = 0, req = 0, slow = 0, retry = 0, flag = 0, p1 = 1, p0 = 0;
  logic [5:0] addr = 6'h01;
  logic [15:0] wd = 16'h0000, rd;
  logic grant, rdy, bus_retry_input, breq, done, act, q1, q0, e1, e0;
  int num_errors = 0, samples_checked = 0, cyc = 0, n;
  dbmc_bus_model u_bus (.i_clk(i_clk), .i_bus_request(breq), .i_cycle_active(act), .i_slow(slow),
    .i_retry(retry), .o_hold_grant(grant), .o_ready(rdy), .o_retry(bus_retry_input));
  dbmc_top DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wd),
    .o_reg_rdata(rd), .i_dma_req(req), .i_block_mode(1'b1), .i_bus_style_select(slow),
    .i_hold_grant(grant), .i_grant_acknowledge(1'b0), .i_ready_in(rdy), .i_port_ack(rdy),
    .i_bus_retry_input(bus_retry_input), .i_retry_pending_flag(flag), .i_user_pin1_in(p1), .i_user_pin0_in(p0),
    .o_user_pin1_out(q1), .o_user_pin0_out(q0), .o_user_pin1_oe(e1), .o_user_pin0_oe(e0),
    .o_bus_request(breq), .o_cycle_done(done), .o_cycle_active(act));
  initial forever #10 i_clk = ~i_clk;
  // Hang guard: far above the fewer than 200 cycles the tests need
  always @(posedge i_clk) if (++cyc > 3000) begin num_errors++; finish_test(); end
  task wreg(input logic [15:0] d);
    @(negedge i_clk) wd = d; wr = 1;
    @(negedge i_clk) wr = 0;
  endtask
  // Bounded wait for the cycle flag to reach a level
  task wact(input logic l, input string s);
    for (int k = 0; k < 40 && act !== l; k++) @(negedge i_clk);
    `CHK(s, l, act)
  endtask
  task finish_test();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge i_clk);
    i_rst_b = 1;
    repeat (8) @(negedge i_clk);
    `CHK("strap", 2'h2, rd[9:8])
    p1 = 0; p0 = 1;
    wreg(16'hFFFF);
    `CHK("mask", 16'hBEDF, rd)
    $display("straps done");
    // Each wait code; pin levels and ready modes vary with it
    for (int w = 0; w < 4; w++) begin
      slow = w[0];
      wreg({3'h0, w[0], ~w[0], w[1], 2'h0, w[1:0], 6'h00});
      req = 1;
      wact(1, "start");
      `CHK("pin1", w[0], q1)
      `CHK("pin0", ~w[0], q0)
      `CHK("oe", 1'b1, e1)
      for (n = 0; n < 40 && done !== 1; n++) @(negedge i_clk);
      `CHK("len", 1'b1, n >= w + 2)
      req = 0;
      wact(0, "idle");
    end
    $display("waits done");
    slow = 0;
    wreg(16'h0000);
    req = 1;
    wact(1, "u_run");
    retry = 1;
    wact(0, "u_stop");
    repeat (10) @(negedge i_clk);
    `CHK("u_hold", 1'b0, act)
    retry = 0;
    wact(1, "u_go");
    wreg(16'h2000);
    flag = 1;
    retry = 1;
    @(negedge i_clk) retry = 0;
    wact(0, "l_stop");
    repeat (10) @(negedge i_clk);
    `CHK("l_hold", 1'b0, act)
    flag = 0;
    wact(1, "l_go");
    $display("retry done");
    finish_test();
  end
endmodule
